// *** dtc_pkg.sv ***
// dtc_pkg: register map, field positions, codes and carrier types for the dual timer block
// assumes an AXI4-Lite master on the same clock; registers are 8 bits in the low byte lane
package dtc_pkg;

  // ----------------------------------------
  // register indexes (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h88;
  localparam logic [7:0] IDX_MODE = 8'h89;
  localparam logic [7:0] IDX_T0LOW = 8'h8A;
  localparam logic [7:0] IDX_T1LOW = 8'h8B;
  localparam logic [7:0] IDX_T0HIGH = 8'h8C;
  localparam logic [7:0] IDX_T1HIGH = 8'h8D;
  localparam logic [7:0] IDX_CLKSEL = 8'h8E;
  localparam logic [7:0] IDX_POL = 8'h8F;
  localparam logic [7:0] IDX_CTRL_SET = 8'h90;
  localparam logic [7:0] IDX_CTRL_CLR = 8'h91;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_NIB = 4'h0;

  // ----------------------------------------
  // control register bits
  // ----------------------------------------
  localparam int CTRL_T1_OVF = 7;
  localparam int CTRL_T1_RUN = 6;
  localparam int CTRL_T0_OVF = 5;
  localparam int CTRL_T0_RUN = 4;
  localparam int CTRL_IRQ1_FLAG = 3;
  localparam int CTRL_IRQ1_TYPE = 2;
  localparam int CTRL_IRQ0_FLAG = 1;
  localparam int CTRL_IRQ0_TYPE = 0;

  // ----------------------------------------
  // mode register fields
  // ----------------------------------------
  localparam int MOD_T1_GATE = 7;
  localparam int MOD_T1_CNT = 6;
  localparam int MOD_T1_MODE = 4;
  localparam int MOD_T0_GATE = 3;
  localparam int MOD_T0_CNT = 2;
  localparam int MOD_T0_MODE = 0;

  localparam logic [1:0] MODE_13 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_RLD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // ----------------------------------------
  // clock select and polarity fields
  // ----------------------------------------
  localparam int CKS_CODE = 0;
  localparam int CKS_T0_SYS = 2;
  localparam int CKS_T1_SYS = 3;
  localparam int POL_IRQ0 = 0;
  localparam int POL_IRQ1 = 1;

  localparam logic [1:0] PRE_SYS12 = 2'h0;
  localparam logic [1:0] PRE_SYS4 = 2'h1;
  localparam logic [1:0] PRE_SYS48 = 2'h2;
  localparam logic [1:0] PRE_EXT8 = 2'h3;
  localparam logic [5:0] DIV_SYS12 = 6'h0C;
  localparam logic [5:0] DIV_SYS4 = 6'h04;
  localparam logic [5:0] DIV_SYS48 = 6'h30;
  localparam logic [2:0] DIV_EXT8_LAST = 3'h7;

  // ----------------------------------------
  // pins and vector acknowledges
  // ----------------------------------------
  localparam int NPINS = 5;
  localparam int PIN_T0 = 0;
  localparam int PIN_T1 = 1;
  localparam int PIN_IRQ0 = 2;
  localparam int PIN_IRQ1 = 3;
  localparam int PIN_EXTCLK = 4;
  localparam int ACK_T0 = 0;
  localparam int ACK_T1 = 1;
  localparam int ACK_IRQ0 = 2;
  localparam int ACK_IRQ1 = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } dtc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dtc_axi_rsp_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] t0Low;
    logic [7:0] t0High;
    logic [7:0] t1Low;
    logic [7:0] t1High;
    logic [3:0] clkSel;
    logic [1:0] pol;
    logic [5:0] preCnt;
    logic [2:0] extCnt;
    logic awHeld;
    logic wHeld;
    logic [11:0] awAddr;
    logic [7:0] wData;
    logic wLane0;
    logic t1OvfPulse;
    dtc_axi_rsp_t rsp;
  } dtc_state_t;

endpackage : dtc_pkg

// *** dtc_pin_sync.sv ***
// dtc_pin_sync: two-flop synchronisers and edge detectors for the external pins
// assumes pins are asynchronous to clk
`timescale 1ns/10ps
module dtc_pin_sync (
  clk,
  rst_b,
  pinIn,
  level,
  fell,
  rose
);
  input wire logic clk;
  input wire logic rst_b;
  input wire logic [dtc_pkg::NPINS-1:0] pinIn;
  output logic [dtc_pkg::NPINS-1:0] level;
  output logic [dtc_pkg::NPINS-1:0] fell;
  output logic [dtc_pkg::NPINS-1:0] rose;

  typedef struct packed {
    logic [dtc_pkg::NPINS-1:0] meta;
    logic [dtc_pkg::NPINS-1:0] sync;
    logic [dtc_pkg::NPINS-1:0] prev;
  } dtc_sync_t;

  dtc_sync_t s;
  dtc_sync_t next_s;

  // ----------------------------------------
  // sample chain
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.meta = pinIn;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
  end

  // pins idle high: reset to ones so no false edge or active level follows reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  // edges compare consecutive synchronised samples
  assign level = s.sync;
  assign fell = s.prev & ~s.sync;
  assign rose = ~s.prev & s.sync;

endmodule : dtc_pin_sync

// *** dtc_timer_core.sv ***
// dtc_timer_core: two counter/timers with run, mode, gate, prescaler and external interrupt flags
// assumes an AXI4-Lite master on clk and vector acknowledges as one-cycle pulses on clk
`timescale 1ns/10ps

// Notes on behaviour
// - timer 1 overflow sets flag outside split; ack clears
// - run bit 6 enables timer 1 outside split
// - timer 0 overflow sets flag; ack clears
// - run bit 4 enables timer 0
// - irq1 flag set by edge/level, ack edge-only
// - irq0 flag set by edge/level, ack edge-only
// - bit 2: irq1 level 0, edge 1
// - bit 0: irq0 level 0, edge 1
// - timer 1 gate needs irq1 active outside split
// - timer 0 gate needs irq0 active
// - timer 1 counts clock or pin falls
// - timer 0 counts clock or pin falls
// - timer 1 modes 13/16/reload/inactive
// - timer 0 modes 13/16/reload/split
// - control bits set or cleared singly
// - 13-bit count, rollover sets flag
// - reload low from high on overflow
// - split high byte runs by timer-1 run
// - prescaler divides 12, 4, 48, ext 8
module dtc_timer_core (
  clk,
  rst_b,
  axiReq,
  axiRsp,
  pins,
  vecAck,
  flags,
  t1OvfPulse
);
  input wire logic clk;
  input wire logic rst_b;
  input wire dtc_pkg::dtc_axi_req_t axiReq;
  output dtc_pkg::dtc_axi_rsp_t axiRsp;
  input wire logic [dtc_pkg::NPINS-1:0] pins;
  input wire logic [3:0] vecAck;
  output logic [7:0] flags;
  output logic t1OvfPulse;

  dtc_pkg::dtc_state_t s;
  dtc_pkg::dtc_state_t next_s;
  logic [dtc_pkg::NPINS-1:0] pinLevel;
  logic [dtc_pkg::NPINS-1:0] pinFell;
  logic [dtc_pkg::NPINS-1:0] pinRose;

  dtc_pin_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn(pins),
    .level(pinLevel),
    .fell(pinFell),
    .rose(pinRose)
  );

  // ----------------------------------------
  // one count step: {overflow, high, low}
  // ----------------------------------------
  function automatic logic [16:0] dtcStep(input logic [7:0] lo, input logic [7:0] hi, input logic [1:0] md);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    c16 = {1'b0, hi, lo} + 17'h0_0001;
    c8 = {1'b0, lo} + 9'h001;
    unique case (md)
      dtc_pkg::MODE_13: dtcStep = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      dtc_pkg::MODE_16: dtcStep = c16;
      dtc_pkg::MODE_RLD: dtcStep = {c8[8], hi, c8[8] ? hi : c8[7:0]};
      dtc_pkg::MODE_SPLIT: dtcStep = {c8[8], hi, c8[7:0]};
    endcase
  endfunction : dtcStep

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [1:0] md0;
    logic [1:0] md1;
    logic split;
    logic act0;
    logic act1;
    logic edge0;
    logic edge1;
    logic preTick;
    logic [5:0] div;
    logic t0Tick;
    logic t1Tick;
    logic hiTick;
    logic run0;
    logic run1;
    logic runHi;
    logic [16:0] st0;
    logic [16:0] st1;
    logic [8:0] stHi;
    logic setT0;
    logic setT1;
    logic setI0;
    logic setI1;
    logic doWrite;
    logic wrMapped;
    logic [7:0] wrIdx;
    logic [7:0] rdIdx;
    logic [7:0] rdByte;
    logic rdMapped;
    logic [7:0] c;
    md0 = '0;
    md1 = '0;
    split = 1'b0;
    act0 = 1'b0;
    act1 = 1'b0;
    edge0 = 1'b0;
    edge1 = 1'b0;
    preTick = 1'b0;
    div = '0;
    t0Tick = 1'b0;
    t1Tick = 1'b0;
    hiTick = 1'b0;
    run0 = 1'b0;
    run1 = 1'b0;
    runHi = 1'b0;
    st0 = '0;
    st1 = '0;
    stHi = '0;
    setT0 = 1'b0;
    setT1 = 1'b0;
    setI0 = 1'b0;
    setI1 = 1'b0;
    doWrite = 1'b0;
    wrMapped = 1'b0;
    wrIdx = '0;
    rdIdx = '0;
    rdByte = '0;
    rdMapped = 1'b0;
    c = s.ctrl;
    next_s = s;
    next_s.t1OvfPulse = 1'b0;

    md0 = s.mode[dtc_pkg::MOD_T0_MODE +: 2];
    md1 = s.mode[dtc_pkg::MOD_T1_MODE +: 2];
    split = (md0 == dtc_pkg::MODE_SPLIT);

    // active level of each interrupt input, 1 in polarity means active high
    act0 = (pinLevel[dtc_pkg::PIN_IRQ0] == s.pol[dtc_pkg::POL_IRQ0]);
    act1 = (pinLevel[dtc_pkg::PIN_IRQ1] == s.pol[dtc_pkg::POL_IRQ1]);
    edge0 = s.pol[dtc_pkg::POL_IRQ0] ? pinRose[dtc_pkg::PIN_IRQ0] : pinFell[dtc_pkg::PIN_IRQ0];
    edge1 = s.pol[dtc_pkg::POL_IRQ1] ? pinRose[dtc_pkg::PIN_IRQ1] : pinFell[dtc_pkg::PIN_IRQ1];

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    unique case (s.clkSel[dtc_pkg::CKS_CODE +: 2])
      dtc_pkg::PRE_SYS12: div = dtc_pkg::DIV_SYS12;
      dtc_pkg::PRE_SYS4: div = dtc_pkg::DIV_SYS4;
      dtc_pkg::PRE_SYS48: div = dtc_pkg::DIV_SYS48;
      dtc_pkg::PRE_EXT8: div = '0;
    endcase
    if (s.clkSel[dtc_pkg::CKS_CODE +: 2] == dtc_pkg::PRE_EXT8) begin
      next_s.preCnt = '0;
      if (pinRose[dtc_pkg::PIN_EXTCLK]) begin
        next_s.extCnt = s.extCnt + 3'h1;
        preTick = (s.extCnt == dtc_pkg::DIV_EXT8_LAST);
      end
    end else if (s.preCnt >= div - 6'h01) begin
      next_s.preCnt = '0;
      preTick = 1'b1;
    end else begin
      next_s.preCnt = s.preCnt + 6'h01;
    end

    // ----------------------------------------
    // timer clocks and run gating
    // ----------------------------------------
    hiTick = s.clkSel[dtc_pkg::CKS_T0_SYS] | preTick;
    t0Tick = s.mode[dtc_pkg::MOD_T0_CNT] ? pinFell[dtc_pkg::PIN_T0] : hiTick;
    t1Tick = (s.mode[dtc_pkg::MOD_T1_CNT] && !split) ? pinFell[dtc_pkg::PIN_T1] :
             (s.clkSel[dtc_pkg::CKS_T1_SYS] | preTick);
    run0 = s.ctrl[dtc_pkg::CTRL_T0_RUN] && (!s.mode[dtc_pkg::MOD_T0_GATE] || act0);
    if (split) begin
      run1 = (md1 != dtc_pkg::MODE_SPLIT);
    end else begin
      run1 = s.ctrl[dtc_pkg::CTRL_T1_RUN] && (!s.mode[dtc_pkg::MOD_T1_GATE] || act1) &&
             (md1 != dtc_pkg::MODE_SPLIT);
    end
    runHi = split && s.ctrl[dtc_pkg::CTRL_T1_RUN];

    // ----------------------------------------
    // counting
    // ----------------------------------------
    st0 = dtcStep(s.t0Low, s.t0High, md0);
    st1 = dtcStep(s.t1Low, s.t1High, md1);
    stHi = {1'b0, s.t0High} + 9'h001;
    if (run0 && t0Tick) begin
      next_s.t0Low = st0[7:0];
      next_s.t0High = split ? s.t0High : st0[15:8];
      setT0 = st0[16];
    end
    if (runHi && hiTick) begin
      next_s.t0High = stHi[7:0];
      setT1 = stHi[8];
    end
    if (run1 && t1Tick) begin
      next_s.t1Low = st1[7:0];
      next_s.t1High = st1[15:8];
      next_s.t1OvfPulse = st1[16];
      setT1 = setT1 | (st1[16] && !split);
    end

    // interrupt flag sources
    setI0 = c[dtc_pkg::CTRL_IRQ0_TYPE] ? edge0 : act0;
    setI1 = c[dtc_pkg::CTRL_IRQ1_TYPE] ? edge1 : act1;

    // ----------------------------------------
    // register write
    // ----------------------------------------
    if (axiReq.awvalid && s.rsp.awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = axiReq.awaddr;
      next_s.rsp.awready = 1'b0;
    end
    if (axiReq.wvalid && s.rsp.wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = axiReq.wdata[7:0];
      next_s.wLane0 = axiReq.wstrb[0];
      next_s.rsp.wready = 1'b0;
    end
    doWrite = s.awHeld && s.wHeld && !s.rsp.bvalid;
    wrIdx = s.awAddr[9:2];
    if (doWrite) begin
      wrMapped = (s.awAddr[11:10] == 2'h0) && (wrIdx >= dtc_pkg::IDX_CTRL) && (wrIdx <= dtc_pkg::IDX_CTRL_CLR);
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = wrMapped ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
      if (wrMapped && s.wLane0) begin
        unique case (wrIdx)
          dtc_pkg::IDX_CTRL: c = s.wData;
          dtc_pkg::IDX_CTRL_SET: c = c | s.wData;
          dtc_pkg::IDX_CTRL_CLR: c = c & ~s.wData;
          dtc_pkg::IDX_MODE: next_s.mode = s.wData;
          dtc_pkg::IDX_T0LOW: next_s.t0Low = s.wData;
          dtc_pkg::IDX_T1LOW: next_s.t1Low = s.wData;
          dtc_pkg::IDX_T0HIGH: next_s.t0High = s.wData;
          dtc_pkg::IDX_T1HIGH: next_s.t1High = s.wData;
          dtc_pkg::IDX_CLKSEL: next_s.clkSel = s.wData[3:0];
          dtc_pkg::IDX_POL: next_s.pol = s.wData[1:0];
          default: c = c;
        endcase
      end
    end
    if (s.rsp.bvalid && axiReq.bready) begin
      next_s.rsp.bvalid = 1'b0;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready = 1'b1;
    end

    // ----------------------------------------
    // flag clears by vectoring, then hardware sets win
    // ----------------------------------------
    if (vecAck[dtc_pkg::ACK_T1]) begin
      c[dtc_pkg::CTRL_T1_OVF] = 1'b0;
    end
    if (vecAck[dtc_pkg::ACK_T0]) begin
      c[dtc_pkg::CTRL_T0_OVF] = 1'b0;
    end
    if (vecAck[dtc_pkg::ACK_IRQ1] && s.ctrl[dtc_pkg::CTRL_IRQ1_TYPE]) begin
      c[dtc_pkg::CTRL_IRQ1_FLAG] = 1'b0;
    end
    if (vecAck[dtc_pkg::ACK_IRQ0] && s.ctrl[dtc_pkg::CTRL_IRQ0_TYPE]) begin
      c[dtc_pkg::CTRL_IRQ0_FLAG] = 1'b0;
    end
    c[dtc_pkg::CTRL_T1_OVF] = c[dtc_pkg::CTRL_T1_OVF] | setT1;
    c[dtc_pkg::CTRL_T0_OVF] = c[dtc_pkg::CTRL_T0_OVF] | setT0;
    c[dtc_pkg::CTRL_IRQ1_FLAG] = c[dtc_pkg::CTRL_IRQ1_FLAG] | setI1;
    c[dtc_pkg::CTRL_IRQ0_FLAG] = c[dtc_pkg::CTRL_IRQ0_FLAG] | setI0;
    next_s.ctrl = c;

    // ----------------------------------------
    // register read
    // ----------------------------------------
    rdIdx = axiReq.araddr[9:2];
    rdMapped = (axiReq.araddr[11:10] == 2'h0) && (rdIdx >= dtc_pkg::IDX_CTRL) && (rdIdx <= dtc_pkg::IDX_CTRL_CLR);
    unique case (rdIdx)
      dtc_pkg::IDX_CTRL: rdByte = s.ctrl;
      dtc_pkg::IDX_CTRL_SET: rdByte = s.ctrl;
      dtc_pkg::IDX_CTRL_CLR: rdByte = s.ctrl;
      dtc_pkg::IDX_MODE: rdByte = s.mode;
      dtc_pkg::IDX_T0LOW: rdByte = s.t0Low;
      dtc_pkg::IDX_T1LOW: rdByte = s.t1Low;
      dtc_pkg::IDX_T0HIGH: rdByte = s.t0High;
      dtc_pkg::IDX_T1HIGH: rdByte = s.t1High;
      dtc_pkg::IDX_CLKSEL: rdByte = {4'h0, s.clkSel};
      dtc_pkg::IDX_POL: rdByte = {6'h00, s.pol};
      default: rdByte = 8'h00;
    endcase
    if (axiReq.arvalid && s.rsp.arready) begin
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = {24'h00_0000, rdMapped ? rdByte : 8'h00};
      next_s.rsp.rresp = rdMapped ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
    end
    if (s.rsp.rvalid && axiReq.rready) begin
      next_s.rsp.rvalid = 1'b0;
      next_s.rsp.arready = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.ctrl <= dtc_pkg::RESET_BYTE;
      s.mode <= dtc_pkg::RESET_BYTE;
      s.clkSel <= dtc_pkg::RESET_NIB;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign axiRsp = s.rsp;
  assign flags = s.ctrl;
  assign t1OvfPulse = s.t1OvfPulse;

endmodule : dtc_timer_core

// *** dtc_timer_core_asserts.sv ***
// dtc_timer_core_asserts: bus handshake and flag checks at the timer core ports
// assumes bound to dtc_timer_core, one clock, async active-low reset
`timescale 1ns/10ps
module dtc_timer_core_asserts (
  clk,
  rst_b,
  axiReq,
  axiRsp,
  pins,
  vecAck,
  flags,
  t1OvfPulse
);
  input wire logic clk;
  input wire logic rst_b;
  input wire dtc_pkg::dtc_axi_req_t axiReq;
  input wire dtc_pkg::dtc_axi_rsp_t axiRsp;
  input wire logic [dtc_pkg::NPINS-1:0] pins;
  input wire logic [3:0] vecAck;
  input wire logic [7:0] flags;
  input wire logic t1OvfPulse;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  reset_state_a: assert property ($rose(rst_b) |-> flags == 8'h00 && !axiRsp.bvalid && axiRsp.awready)
    else $error("state not clear after reset");
  write_resp_a: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready |->
    ##2 axiRsp.bvalid && !axiRsp.awready) else $error("write response missing");
  read_resp_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready)
    else $error("read response missing");
  resp_hold_a: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data dropped");
  ctrl_read_a: assert property (axiReq.arvalid && axiRsp.arready && axiReq.araddr == 12'h220 |=>
    axiRsp.rdata == {24'h00_0000, $past(flags)}) else $error("control read mismatch");
  t0_ack_clear_a: assert property (vecAck[0] && !flags[4] && axiRsp.awready |=> !flags[5])
    else $error("timer0 flag not cleared by vector");
  t1_ack_clear_a: assert property (vecAck[1] && !flags[6] && axiRsp.awready |=> !flags[7])
    else $error("timer1 flag not cleared by vector");
  irq0_level_keep_a: assert property (vecAck[2] && flags[1] && !flags[0] && axiRsp.awready |=> flags[1])
    else $error("level irq0 flag cleared by vector");
  irq1_level_keep_a: assert property (vecAck[3] && flags[3] && !flags[2] && axiRsp.awready |=> flags[3])
    else $error("level irq1 flag cleared by vector");

  t1_flag_c: cover property ($rose(flags[7]));
  irq0_flag_c: cover property ($rose(flags[1]));
  t1_pulse_c: cover property (t1OvfPulse);
  write_done_c: cover property (axiRsp.bvalid && axiReq.bready);
endmodule : dtc_timer_core_asserts

bind dtc_timer_core dtc_timer_core_asserts u_chk (.clk(clk), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(axiRsp),
  .pins(pins), .vecAck(vecAck), .flags(flags), .t1OvfPulse(t1OvfPulse));

// *** dtc_pin_model.sv ***
// dtc_pin_model: external count and interrupt pins plus cpu vector acknowledges
// assumes callers use its tasks from a clocked sequence on clk
`timescale 1ns/10ps
module dtc_pin_model (
  clk,
  pins,
  vecAck
);
  input wire logic clk;
  output logic [dtc_pkg::NPINS-1:0] pins;
  output logic [3:0] vecAck;

  // ----------------------------------------
  // pin levels and vector pulses
  // ----------------------------------------
  initial begin
    pins = 5'h1F;
    vecAck = 4'h0;
  end

  task automatic set_pin(input int idx, input logic val);
    @(posedge clk);
    pins[idx] <= val;
  endtask : set_pin

  task automatic ack(input int idx);
    @(posedge clk);
    vecAck[idx] <= 1'b1;
    @(posedge clk);
    vecAck[idx] <= 1'b0;
  endtask : ack
endmodule : dtc_pin_model

// *** dtc_timer_core_test.sv ***
// dtc_timer_core_test: register and timer sequences through the bus
// assumes a 200 MHz clock and the pin model as the far side
`timescale 1ns/10ps
module dtc_timer_core_test;
  logic clk;
  logic rst_b;
  dtc_pkg::dtc_axi_req_t req;
  dtc_pkg::dtc_axi_rsp_t rsp;
  logic [dtc_pkg::NPINS-1:0] pins;
  logic [3:0] vecAck;
  logic [7:0] flags;
  logic t1Pulse;
  int pulseCount;
  int pulseBase;
  int badCount;
  int totalChecks;
  int cycles;

  dtc_timer_core uut (.clk(clk), .rst_b(rst_b), .axiReq(req), .axiRsp(rsp), .pins(pins), .vecAck(vecAck),
    .flags(flags), .t1OvfPulse(t1Pulse));
  dtc_pin_model pm (.clk(clk), .pins(pins), .vecAck(vecAck));

  // ----------------------------------------
  // clock, timeout, report
  // ----------------------------------------
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finishTest

  always @(posedge clk) begin
    if (t1Pulse === 1'b1) begin
      pulseCount++;
    end
    cycles++;
    if (cycles == 8000) begin
      badCount++;
      finishTest();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] data, input logic [1:0] expResp);
    logic takeA;
    logic takeW;
    logic done;
    logic [1:0] resp;
    done = 1'b0;
    @(posedge clk);
    req.awaddr <= {2'h0, idx, 2'h0};
    req.wdata <= {24'h00_0000, data};
    req.wstrb <= 4'h1;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      takeA = req.awvalid && rsp.awready;
      takeW = req.wvalid && rsp.wready;
      done = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge clk);
      if (takeA) req.awvalid <= 1'b0;
      if (takeW) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    check({6'h00, resp}, {6'h00, expResp});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] expResp);
    logic takeR;
    logic done;
    logic [7:0] data;
    logic [1:0] resp;
    done = 1'b0;
    @(posedge clk);
    req.araddr <= {2'h0, idx, 2'h0};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      takeR = req.arvalid && rsp.arready;
      done = rsp.rvalid;
      data = rsp.rdata[7:0];
      resp = rsp.rresp;
      @(posedge clk);
      if (takeR) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    check(data, exp);
    check({6'h00, resp}, {6'h00, expResp});
  endtask : axi_read

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    req = '0;
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    axi_read(dtc_pkg::IDX_CTRL, 8'h00, dtc_pkg::RESP_OKAY);
    axi_read(dtc_pkg::IDX_MODE, 8'h00, dtc_pkg::RESP_OKAY);
    axi_read(8'h92, 8'h00, dtc_pkg::RESP_SLVERR);
    axi_write(8'h92, 8'h55, dtc_pkg::RESP_SLVERR);
    axi_write(dtc_pkg::IDX_MODE, 8'hA5, dtc_pkg::RESP_OKAY);
    axi_read(dtc_pkg::IDX_MODE, 8'hA5, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_SET, 8'h04, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_SET, 8'h01, dtc_pkg::RESP_OKAY);
    axi_read(dtc_pkg::IDX_CTRL, 8'h05, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_CLR, 8'h04, dtc_pkg::RESP_OKAY);
    axi_read(dtc_pkg::IDX_CTRL, 8'h01, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_CLR, 8'h01, dtc_pkg::RESP_OKAY);
    // timer0 13-bit rollover from 0x1FFE
    axi_write(dtc_pkg::IDX_MODE, 8'h00, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CLKSEL, 8'h0C, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T0HIGH, 8'hFF, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T0LOW, 8'h1E, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_SET, 8'h10, dtc_pkg::RESP_OKAY);
    wait_cyc(10);
    check(flags & 8'h20, 8'h20);
    axi_write(dtc_pkg::IDX_CTRL_CLR, 8'h10, dtc_pkg::RESP_OKAY);
    pm.ack(0);
    wait_cyc(2);
    check(flags & 8'h20, 8'h00);
    // timer1 reload mode
    axi_write(dtc_pkg::IDX_MODE, 8'h20, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T1HIGH, 8'hF0, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T1LOW, 8'hFE, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_SET, 8'h40, dtc_pkg::RESP_OKAY);
    wait_cyc(10);
    axi_write(dtc_pkg::IDX_CTRL_CLR, 8'h40, dtc_pkg::RESP_OKAY);
    check(flags & 8'h80, 8'h80);
    axi_read(dtc_pkg::IDX_T1HIGH, 8'hF0, dtc_pkg::RESP_OKAY);
    pm.ack(1);
    wait_cyc(2);
    check(flags & 8'h80, 8'h00);
    // timer1 inactive mode
    axi_write(dtc_pkg::IDX_MODE, 8'h30, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T1LOW, 8'h00, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_SET, 8'h40, dtc_pkg::RESP_OKAY);
    wait_cyc(20);
    axi_read(dtc_pkg::IDX_T1LOW, 8'h00, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_CLR, 8'h40, dtc_pkg::RESP_OKAY);
    // timer0 gated by irq0, level irq0
    axi_write(dtc_pkg::IDX_MODE, 8'h0A, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T0HIGH, 8'h00, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T0LOW, 8'hF0, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_SET, 8'h10, dtc_pkg::RESP_OKAY);
    wait_cyc(20);
    check(flags & 8'h20, 8'h00);
    pm.set_pin(dtc_pkg::PIN_IRQ0, 1'b0);
    wait_cyc(25);
    check(flags & 8'h22, 8'h22);
    pm.set_pin(dtc_pkg::PIN_IRQ0, 1'b1);
    wait_cyc(4);
    pm.ack(2);
    wait_cyc(2);
    check(flags & 8'h02, 8'h02);
    axi_write(dtc_pkg::IDX_CTRL_CLR, 8'h32, dtc_pkg::RESP_OKAY);
    axi_read(dtc_pkg::IDX_CTRL, 8'h00, dtc_pkg::RESP_OKAY);
    // timer0 counting pin falls
    axi_write(dtc_pkg::IDX_MODE, 8'h05, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T0LOW, 8'h00, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_SET, 8'h10, dtc_pkg::RESP_OKAY);
    repeat (3) begin
      pm.set_pin(dtc_pkg::PIN_T0, 1'b0);
      wait_cyc(4);
      pm.set_pin(dtc_pkg::PIN_T0, 1'b1);
      wait_cyc(4);
    end
    wait_cyc(4);
    axi_read(dtc_pkg::IDX_T0LOW, 8'h03, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_CLR, 8'h10, dtc_pkg::RESP_OKAY);
    // timer0 on external clock divided by 8
    axi_write(dtc_pkg::IDX_MODE, 8'h01, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CLKSEL, 8'h03, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T0LOW, 8'h00, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_SET, 8'h10, dtc_pkg::RESP_OKAY);
    repeat (8) begin
      pm.set_pin(dtc_pkg::PIN_EXTCLK, 1'b0);
      pm.set_pin(dtc_pkg::PIN_EXTCLK, 1'b1);
    end
    wait_cyc(4);
    axi_read(dtc_pkg::IDX_T0LOW, 8'h01, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CTRL_CLR, 8'h10, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_CLKSEL, 8'h0C, dtc_pkg::RESP_OKAY);
    // timer0 split: high byte on timer1 run, timer1 only pulses
    axi_write(dtc_pkg::IDX_T1HIGH, 8'hFF, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T1LOW, 8'h1F, dtc_pkg::RESP_OKAY);
    axi_write(dtc_pkg::IDX_T0HIGH, 8'hFE, dtc_pkg::RESP_OKAY);
    pulseBase = pulseCount;
    axi_write(dtc_pkg::IDX_MODE, 8'h03, dtc_pkg::RESP_OKAY);
    wait_cyc(2);
    check(8'(pulseCount - pulseBase), 8'h01);
    check(flags & 8'h80, 8'h00);
    axi_write(dtc_pkg::IDX_CTRL_SET, 8'h40, dtc_pkg::RESP_OKAY);
    wait_cyc(4);
    check(flags & 8'h80, 8'h80);
    axi_write(dtc_pkg::IDX_CTRL_CLR, 8'hC0, dtc_pkg::RESP_OKAY);
    // edge irq1
    axi_write(dtc_pkg::IDX_CTRL_SET, 8'h04, dtc_pkg::RESP_OKAY);
    pm.set_pin(dtc_pkg::PIN_IRQ1, 1'b0);
    wait_cyc(6);
    check(flags & 8'h08, 8'h08);
    pm.ack(3);
    wait_cyc(2);
    check(flags & 8'h08, 8'h00);
    pm.set_pin(dtc_pkg::PIN_IRQ1, 1'b1);
    wait_cyc(4);
    finishTest();
  end
endmodule : dtc_timer_core_test
